// File: logic/ioxr_target.sv
// Purpose: I2C target, command decode and register file of the expander.
// Assumes: SCL and SDA are oversampled by the 100 MHz clock.
// Notes: SDA is open drain; the block only ever pulls it low.
`timescale 1ns/1ps
module ioxr_target
  import ioxr_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  input wire logic hw_reset_n,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Address straps
  input wire logic addr_select_low,
  input wire logic addr_select_high,
  // Port pin levels
  input wire logic [7:0] port0_in,
  input wire logic [7:0] port1_in,
  // Register contents
  output logic [7:0] output_level_p0,
  output logic [7:0] output_level_p1,
  output logic [7:0] invert_p0,
  output logic [7:0] invert_p1,
  output logic [7:0] direction_p0,
  output logic [7:0] direction_p1,
  output logic [7:0] drive_mode_p0,
  output logic [7:0] drive_mode_p1,
  output logic [7:0] fault_flag_enable_p0,
  output logic [7:0] fault_flag_enable_p1,
  // Interrupt
  output logic irq_out_n
);
  logic [SYNC_W-1:0] sync_s;
  logic scl_s, sda_s, sel_lo_s, sel_hi_s, hwr_s, srst;
  logic [7:0] pin0_s, pin1_s;
  logic scl_d_q, sda_d_q, scl_rise, scl_fall, start_det, stop_det;
  ioxr_state_t state_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q, tx_q;
  logic rd_q, ack_seen_q, sda_oe_n_q;
  logic [3:0] ptr_q;
  logic cmd_valid_q;
  logic [7:0] rw_q [RW_FIRST:NUM_REGS-1];
  logic [7:0] snap0_q, snap1_q;
  logic irq_q, srst_q;
  logic [7:0] rd_val;
  logic byte_in, addr_hit, cmd_ok, cmd_take, wr_take, rd_load;

  ioxr_sync #(.W(SYNC_W), .RST(SYNC_RST)) u_sync (
    .clock(clock),
    .nrst(nrst),
    .d({port1_in, port0_in, hw_reset_n, addr_select_high,
        addr_select_low, sda_in, scl_in}),
    .q(sync_s)
  );
  assign scl_s = sync_s[0];
  assign sda_s = sync_s[1];
  assign sel_lo_s = sync_s[2];
  assign sel_hi_s = sync_s[3];
  assign hwr_s = sync_s[4];
  assign pin0_s = sync_s[12:5];
  assign pin1_s = sync_s[20:13];
  // Reset pin acts synchronously after its synchroniser
  assign srst = ~hwr_s;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      scl_d_q <= scl_s;
      sda_d_q <= sda_s;
    end
  end
  assign scl_rise = scl_s & ~scl_d_q;
  assign scl_fall = ~scl_s & scl_d_q;
  assign start_det = scl_s & scl_d_q & sda_d_q & ~sda_s;
  assign stop_det = scl_s & scl_d_q & ~sda_d_q & sda_s;

  assign byte_in = scl_fall && (cnt_q == BYTE_BITS);
  assign addr_hit = shift_q[7:1] == {ADDR_BASE, sel_hi_s, sel_lo_s};
  assign cmd_ok = (shift_q[7:4] == CMD_UPPER_ZERO) &&
                  (shift_q[3:0] <= CMD_LAST);
  assign cmd_take = (state_q == ST_CMD) && byte_in && cmd_ok;
  assign wr_take = (state_q == ST_WDATA) && byte_in;
  assign rd_load = scl_rise && (((state_q == ST_ADDR_ACK) && rd_q) ||
                   ((state_q == ST_RACK) && !sda_s));

  // Input registers show live pins through the inversion mask
  always_comb begin
    unique case (ptr_q)
      REG_IN_P0: rd_val = pin0_s ^ rw_q[REG_INV_P0];
      REG_IN_P1: rd_val = pin1_s ^ rw_q[REG_INV_P1];
      default: rd_val = rw_q[ptr_q];
    endcase
  end

  // Bus sequencer; a start or stop overrides any state
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      shift_q <= '0;
      rd_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
    end else if (srst || stop_det) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      sda_oe_n_q <= 1'b1;
    end else if (start_det) begin
      state_q <= ST_ADDR;
      cnt_q <= '0;
      sda_oe_n_q <= 1'b1;
    end else begin
      if (scl_rise && (state_q == ST_ADDR || state_q == ST_CMD ||
                       state_q == ST_WDATA)) begin
        shift_q <= {shift_q[6:0], sda_s};
        cnt_q <= cnt_q + 4'h1;
      end
      if (scl_fall) begin
        unique case (state_q)
          ST_ADDR: begin
            if (byte_in) begin
              cnt_q <= '0;
              // Read needs a pointer set by an earlier command
              if (addr_hit && (!shift_q[0] || cmd_valid_q)) begin
                sda_oe_n_q <= 1'b0;
                rd_q <= shift_q[0];
                state_q <= ST_ADDR_ACK;
              end else begin
                state_q <= ST_WAIT;
              end
            end
          end
          ST_ADDR_ACK: begin
            if (rd_q) begin
              state_q <= ST_RDATA;
              sda_oe_n_q <= tx_q[7];
            end else begin
              state_q <= ST_CMD;
              sda_oe_n_q <= 1'b1;
            end
          end
          ST_CMD: begin
            if (byte_in) begin
              cnt_q <= '0;
              if (cmd_ok) begin
                sda_oe_n_q <= 1'b0;
                state_q <= ST_CMD_ACK;
              end else begin
                state_q <= ST_WAIT;
              end
            end
          end
          ST_CMD_ACK, ST_WDATA_ACK: begin
            state_q <= ST_WDATA;
            sda_oe_n_q <= 1'b1;
          end
          ST_WDATA: begin
            if (byte_in) begin
              cnt_q <= '0;
              sda_oe_n_q <= 1'b0;
              state_q <= ST_WDATA_ACK;
            end
          end
          ST_RDATA: begin
            if (cnt_q == BIT_LAST) begin
              cnt_q <= '0;
              sda_oe_n_q <= 1'b1;
              state_q <= ST_RACK;
            end else begin
              cnt_q <= cnt_q + 4'h1;
              sda_oe_n_q <= tx_q[6];
            end
          end
          ST_RACK: begin
            // Any number of bytes while the controller acks
            if (ack_seen_q) begin
              state_q <= ST_RDATA;
              sda_oe_n_q <= tx_q[7];
            end else begin
              state_q <= ST_WAIT;
            end
          end
          ST_IDLE, ST_WAIT: begin
            sda_oe_n_q <= 1'b1;
          end
        endcase
      end
    end
  end

  // Transmit holder; loaded before the byte leaves
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tx_q <= '0;
      ack_seen_q <= 1'b0;
    end else begin
      if (rd_load) begin
        tx_q <= rd_val;
      end else if (scl_fall && state_q == ST_RDATA) begin
        tx_q <= {tx_q[6:0], 1'b0};
      end
      if (scl_rise && state_q == ST_RACK) begin
        ack_seen_q <= ~sda_s;
      end
    end
  end

  // Pointer: set by command, toggles within the pair per byte
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ptr_q <= '0;
      cmd_valid_q <= 1'b0;
    end else if (srst) begin
      ptr_q <= '0;
      cmd_valid_q <= 1'b0;
    end else if (cmd_take) begin
      ptr_q <= shift_q[3:0];
      cmd_valid_q <= 1'b1;
    end else if (rd_load || wr_take) begin
      ptr_q <= {ptr_q[3:1], ~ptr_q[0]};
    end
  end

  // Writable registers; input registers have no storage to write
  for (genvar i = RW_FIRST; i < NUM_REGS; i++) begin : g_rw
    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        rw_q[i] <= ioxr_rst_val(4'(i));
      end else if (srst) begin
        rw_q[i] <= ioxr_rst_val(4'(i));
      end else if (wr_take && ptr_q == 4'(i)) begin
        rw_q[i] <= shift_q;
      end
    end
  end

  // Change detect; snapshot retaken once synced pins settle after reset
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      snap0_q <= '0;
      snap1_q <= '0;
      irq_q <= 1'b1;
      srst_q <= 1'b1;
    end else begin
      srst_q <= srst;
      if (srst || srst_q || (rd_load && ptr_q == REG_IN_P0)) begin
        snap0_q <= pin0_s;
      end
      if (srst || srst_q || (rd_load && ptr_q == REG_IN_P1)) begin
        snap1_q <= pin1_s;
      end
      irq_q <= srst_q || ((pin0_s == snap0_q) && (pin1_s == snap1_q));
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_n = sda_oe_n_q;
  assign irq_out_n = irq_q;
  assign output_level_p0 = rw_q[REG_OUT_P0];
  assign output_level_p1 = rw_q[REG_OUT_P1];
  assign invert_p0 = rw_q[REG_INV_P0];
  assign invert_p1 = rw_q[REG_INV_P1];
  assign direction_p0 = rw_q[REG_DIR_P0];
  assign direction_p1 = rw_q[REG_DIR_P1];
  assign drive_mode_p0 = rw_q[REG_DRV_P0];
  assign drive_mode_p1 = rw_q[REG_DRV_P1];
  assign fault_flag_enable_p0 = rw_q[REG_FLT_P0];
  assign fault_flag_enable_p1 = rw_q[REG_FLT_P1];

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_stop_idle: assert property (stop_det |=>
    state_q == ST_IDLE && sda_oe_n_q) else $error("stop not idle");
  a_read_nocmd: assert property (
    state_q == ST_ADDR && byte_in && shift_q[0] && !cmd_valid_q &&
    !srst && !stop_det && !start_det |=> state_q == ST_WAIT && sda_oe_n_q)
    else $error("read acked without command");
  a_addr_miss: assert property (
    state_q == ST_ADDR && byte_in && !addr_hit && !srst && !stop_det &&
    !start_det |=> state_q == ST_WAIT) else $error("foreign address acked");
  a_cmd_reject: assert property (
    state_q == ST_CMD && byte_in && !cmd_ok && !srst && !stop_det &&
    !start_det |=> state_q == ST_WAIT && $stable(ptr_q))
    else $error("bad command taken");
  a_cmd_pointer: assert property (cmd_take && !srst |=>
    ptr_q == $past(shift_q[3:0]) && cmd_valid_q)
    else $error("command not stored");
  a_read_alt: assert property (rd_load && !srst && !cmd_take |=>
    ptr_q[0] != $past(ptr_q[0]) && ptr_q[3:1] == $past(ptr_q[3:1]))
    else $error("pointer did not alternate");
  a_tx_capture: assert property (rd_load |=> tx_q == $past(rd_val))
    else $error("transmit holder not loaded");
  a_out_write: assert property (
    wr_take && ptr_q == REG_OUT_P0 && !srst |=>
    output_level_p0 == $past(shift_q)) else $error("output write lost");
  a_irq_clear: assert property (
    rd_load && ptr_q == REG_IN_P0 && pin1_s == snap1_q && !srst ##1
    $stable(pin0_s) && $stable(pin1_s) |=> irq_out_n)
    else $error("interrupt not cleared");
  a_reset_idle: assert property (srst |=>
    state_q == ST_IDLE && !cmd_valid_q && ptr_q == 4'h0)
    else $error("reset not applied");
  a_read_more: assert property (
    state_q == ST_RACK && scl_fall && ack_seen_q && !srst && !stop_det &&
    !start_det |=> state_q == ST_RDATA) else $error("read stopped early");
  a_dir_bit: assert property (
    state_q == ST_ADDR_ACK && scl_fall && !srst && !stop_det && !start_det
    |=> state_q == (rd_q ? ST_RDATA : ST_CMD)) else $error("direction wrong");

  c_write_data: cover property (state_q == ST_WDATA_ACK && scl_fall);
  c_read_two: cover property (rd_load && state_q == ST_RACK);
  c_cmd_reject: cover property (state_q == ST_CMD && byte_in && !cmd_ok);
  c_irq_set: cover property (!irq_out_n);
endmodule : ioxr_target

// File: logic/ioxr_pkg.sv
// Purpose: Shared constants and types of the I/O expander bus target.
// Assumes: Registers are 8 bits, command codes 0x00 to 0x0B.
// Notes: Reset values not known here are plain defaults.
package ioxr_pkg;
  localparam int NUM_REGS = 12;
  localparam int RW_FIRST = 2;
  localparam int SYNC_W = 21;
  localparam logic [4:0] ADDR_BASE = 5'h1D;
  localparam logic [3:0] CMD_LAST = 4'hB;
  localparam logic [3:0] CMD_UPPER_ZERO = 4'h0;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] REG_IN_P0 = 4'h0;
  localparam logic [3:0] REG_IN_P1 = 4'h1;
  localparam logic [3:0] REG_OUT_P0 = 4'h2;
  localparam logic [3:0] REG_OUT_P1 = 4'h3;
  localparam logic [3:0] REG_INV_P0 = 4'h4;
  localparam logic [3:0] REG_INV_P1 = 4'h5;
  localparam logic [3:0] REG_DIR_P0 = 4'h6;
  localparam logic [3:0] REG_DIR_P1 = 4'h7;
  localparam logic [3:0] REG_DRV_P0 = 4'h8;
  localparam logic [3:0] REG_DRV_P1 = 4'h9;
  localparam logic [3:0] REG_FLT_P0 = 4'hA;
  localparam logic [3:0] REG_FLT_P1 = 4'hB;
  localparam logic [7:0] RST_OUT_LEVEL = 8'hFF;
  localparam logic [7:0] RST_INVERT = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'hFF;
  localparam logic [7:0] RST_DRIVE_MODE = 8'h00;
  localparam logic [7:0] RST_FAULT_EN = 8'h00;
  // Order: port1 pins, port0 pins, reset pin, addr high, addr low, sda, scl
  localparam logic [SYNC_W-1:0] SYNC_RST = 21'h000003;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK, ST_WAIT
  } ioxr_state_t;

  function automatic logic [7:0] ioxr_rst_val(input logic [3:0] idx);
    logic [2:0] kind;
    kind = idx[3:1];
    unique case (kind)
      3'h1: ioxr_rst_val = RST_OUT_LEVEL;
      3'h2: ioxr_rst_val = RST_INVERT;
      3'h3: ioxr_rst_val = RST_DIRECTION;
      3'h4: ioxr_rst_val = RST_DRIVE_MODE;
      default: ioxr_rst_val = RST_FAULT_EN;
    endcase
  endfunction : ioxr_rst_val
endpackage : ioxr_pkg

// File: logic/ioxr_sync.sv
// Purpose: Two-stage synchroniser for pins entering the clock domain.
// Assumes: Bits are independent levels; no bus coherency needed.
// Notes: First stage is read only by the second stage.
`timescale 1ns/1ps
module ioxr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta_q <= RST;
      q <= RST;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : ioxr_sync

// File: tb/ioxr_ctrl_model.sv
// Purpose: Bus controller model driving SCL and SDA of the expander.
// Assumes: The bench forms the wired SDA level with its pull-up.
// Notes: Lines move on falling clock edges; bits of 12 and 13 clocks, 125 ns mean.
`timescale 1ns/1ps
module ioxr_ctrl_model (
  // Clock
  input wire logic clock,
  // Bus
  input wire logic sda,
  output logic scl,
  output logic sda_drv
);
  bit odd;

  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick

  // Data set mid-low, sampled mid-high, so SDA never moves with SCL high
  task automatic bit_x(input logic b, output logic s);
    scl = 1'b0;
    tick(3);
    sda_drv = b;
    tick(3);
    scl = 1'b1;
    tick(3);
    s = sda;
    // Alternate 12 and 13 clocks so the bit period averages 125 ns
    tick(odd ? 4 : 3);
    odd = !odd;
  endtask : bit_x

  // Also serves as repeated start
  task automatic start;
    scl = 1'b0;
    tick(3);
    sda_drv = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(6);
    sda_drv = 1'b0;
    tick(6);
  endtask : start

  task automatic stop;
    scl = 1'b0;
    tick(3);
    sda_drv = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(6);
    sda_drv = 1'b1;
    tick(6);
  endtask : stop

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(b[i], s);
    bit_x(1'b1, s);
    ack = !s;
  endtask : wbyte

  task automatic rbyte(input logic more, output logic [7:0] q);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, q[i]);
    bit_x(!more, s);
  endtask : rbyte
endmodule : ioxr_ctrl_model

// File: tb/i2c_expander_register_access_tb.sv
// Purpose: Self-checking bench of the expander bus target.
// Assumes: One controller model; SDA pulled up.
// Notes: Rows cover every writable pair; odd cases follow by hand.
`timescale 1ns/1ps
module i2c_expander_register_access_tb;
  import ioxr_pkg::*;
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] d0;
    logic [7:0] d1;
  } ioxr_row_t;
  localparam ioxr_row_t ROWS [5] = '{'{8'h02, 8'h5A, 8'hC3},
    '{8'h06, 8'h12, 8'h34}, '{8'h08, 8'h9E, 8'h61},
    '{8'h0A, 8'hAA, 8'h55}, '{8'h04, 8'h0F, 8'hF0}};
  localparam logic [7:0] RV [2:11] = '{8'hFF, 8'hFF, 8'h00, 8'h00,
    8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
  logic clock, nrst, hw_reset_n, a_lo, a_hi, ak, ac, s;
  logic [7:0] p0, p1;
  logic [7:0] q [5];
  wire scl, sda_drv, sda_out, sda_oe_n, irq_out_n, sda;
  wire [7:0] r [2:11];
  int checks, n_mismatch;

  // Pull-up plus wired-AND of both parties
  assign sda = sda_drv & (sda_oe_n | sda_out);

  ioxr_ctrl_model m (.clock(clock), .sda(sda), .scl(scl),
    .sda_drv(sda_drv));

  ioxr_target DUT (.clock(clock), .nrst(nrst), .hw_reset_n(hw_reset_n),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .addr_select_low(a_lo), .addr_select_high(a_hi),
    .port0_in(p0), .port1_in(p1),
    .output_level_p0(r[2]), .output_level_p1(r[3]),
    .invert_p0(r[4]), .invert_p1(r[5]),
    .direction_p0(r[6]), .direction_p1(r[7]),
    .drive_mode_p0(r[8]), .drive_mode_p1(r[9]),
    .fault_flag_enable_p0(r[10]), .fault_flag_enable_p1(r[11]),
    .irq_out_n(irq_out_n));

  always #5 clock = ~clock;

  task automatic chk_byte(input logic [7:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t byte %h expected %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic got, exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t bit %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  function automatic logic [7:0] adr(input logic rw);
    adr = {5'h1D, a_hi, a_lo, rw};
  endfunction : adr

  // Write with n data bytes; without stop the next read is a restart
  task automatic wr(input logic [7:0] c, d0, d1, input int n,
                    input logic stp);
    m.start();
    m.wbyte(adr(1'b0), ak);
    m.wbyte(c, ac);
    if (n > 0) m.wbyte(d0, s);
    if (n > 1) m.wbyte(d1, s);
    if (stp) m.stop();
  endtask : wr

  task automatic rd(input int n, input logic stp);
    m.start();
    m.wbyte(adr(1'b1), ak);
    for (int i = 0; i < n && ak; i++) m.rbyte(i < n - 1 || !stp, q[i]);
    if (stp) m.stop();
  endtask : rd

  initial begin
    repeat (60000) @(posedge clock);
    n_mismatch++;
    $display("ERROR %0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    clock = 1'b0;
    nrst = 1'b0;
    hw_reset_n = 1'b1;
    {a_hi, a_lo} = 2'b01;
    p0 = 8'hA5;
    p1 = 8'h3C;
    m.tick(20);
    nrst = 1'b1;
    m.tick(12);
    chk_bit(irq_out_n, 1'b1);
    foreach (ROWS[i]) begin
      wr(ROWS[i].cmd, ROWS[i].d0, ROWS[i].d1, 2, 1'b0);
      chk_bit(ak, 1'b1);
      chk_bit(ac, 1'b1);
      chk_byte(r[ROWS[i].cmd], ROWS[i].d0);
      chk_byte(r[ROWS[i].cmd + 1], ROWS[i].d1);
      rd(3, 1'b1);
      chk_byte(q[0], ROWS[i].d0);
      chk_byte(q[1], ROWS[i].d1);
      chk_byte(q[2], ROWS[i].d0);
      $display("row %0d done", i);
    end
    // Long read of the input pair; invert masks are 0F and F0 now
    wr(8'h00, 8'h00, 8'h00, 0, 1'b0);
    rd(5, 1'b1);
    for (int i = 0; i < 5; i++) begin
      chk_byte(q[i], i % 2 ? p1 ^ 8'hF0 : p0 ^ 8'h0F);
    end
    chk_bit(irq_out_n, 1'b1);
    p0 = 8'hA4;
    m.tick(6);
    chk_bit(irq_out_n, 1'b0);
    wr(8'h01, 8'h00, 8'h00, 0, 1'b0);
    rd(1, 1'b1);
    chk_bit(irq_out_n, 1'b0);
    wr(8'h00, 8'h00, 8'h00, 0, 1'b0);
    rd(1, 1'b1);
    m.tick(6);
    chk_bit(irq_out_n, 1'b1);
    // Port 1 change is not cleared by a read of port 0
    p1 = 8'h3D;
    m.tick(6);
    chk_bit(irq_out_n, 1'b0);
    wr(8'h00, 8'h00, 8'h00, 0, 1'b0);
    rd(1, 1'b1);
    chk_bit(irq_out_n, 1'b0);
    wr(8'h01, 8'h00, 8'h00, 0, 1'b0);
    rd(1, 1'b1);
    m.tick(6);
    chk_bit(irq_out_n, 1'b1);
    $display("input and interrupt test done");
    // Restart in mid-read lands on the first register again
    wr(8'h02, 8'h00, 8'h00, 0, 1'b0);
    rd(1, 1'b0);
    rd(1, 1'b1);
    chk_byte(q[0], 8'h5A);
    // Writes to both input registers are ignored
    wr(8'h00, 8'h00, 8'h00, 2, 1'b0);
    rd(2, 1'b1);
    chk_byte(q[0], p0 ^ 8'h0F);
    chk_byte(q[1], p1 ^ 8'hF0);
    // Other strap setting; old address must be refused
    {a_hi, a_lo} = 2'b10;
    m.start();
    m.wbyte(8'hEA, ak);
    m.stop();
    chk_bit(ak, 1'b0);
    wr(8'h0C, 8'h11, 8'h22, 2, 1'b1);
    chk_bit(ak, 1'b1);
    chk_bit(ac, 1'b0);
    wr(8'h10, 8'h11, 8'h22, 2, 1'b1);
    chk_bit(ac, 1'b0);
    chk_byte(r[2], 8'h5A);
    rd(1, 1'b1);
    chk_byte(q[0], p0 ^ 8'h0F);
    $display("address and command test done");
    // Stop in mid-byte, then a clean write
    m.start();
    for (int i = 0; i < 4; i++) m.bit_x(1'b1, s);
    m.stop();
    wr(8'h06, 8'h81, 8'h00, 1, 1'b1);
    chk_byte(r[6], 8'h81);
    // Reset pin restores defaults and forgets the command
    hw_reset_n = 1'b0;
    m.tick(6);
    hw_reset_n = 1'b1;
    m.tick(12);
    for (int i = 2; i < 12; i++) chk_byte(r[i], RV[i]);
    chk_bit(irq_out_n, 1'b1);
    rd(1, 1'b1);
    chk_bit(ak, 1'b0);
    $display("stop and reset test done");
    finish_test();
  end
endmodule : i2c_expander_register_access_tb
